// ===== include/trip_defines.vh
`ifndef TRIP_DEFINES_VH
`define TRIP_DEFINES_VH
// Timing base
`define CLK_PERIOD_NS 10
`define TICK_PERIOD_NS 1000000
`define TICK_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define TICK_MS 1
`define RUNUP_WINDOW_MS 100
`define SETTLE_MS 500
`define INTEG_MS 15
`define RUNUP_WINDOW_TICKS (`RUNUP_WINDOW_MS / `TICK_MS)
`define SETTLE_TICKS (`SETTLE_MS / `TICK_MS)
`define INTEG_TICKS (`INTEG_MS / `TICK_MS)
// Register byte offsets
`define OFF_BASE 8'h00
`define OFF_STATUS 8'h04
`define OFF_CMD 8'h08
`define OFF_MODE 8'h0c
`define OFF_SET0 8'h10
`define OFF_RUNUP 8'h28
`define OFF_HEAT_LIM 8'h2c
`define OFF_RATIO 8'h30
`define OFF_HEAT_ACC 8'h34
`define OFF_MAT0 8'h40
// Command and field positions
`define CMD_RESET_BIT 0
`define CMD_SELECT_BIT 1
`define CMD_FSM_RST_BIT 2
`define CMD_MASK_LSB 16
`define MAT_LATCH_BIT 8
`define STAT_TRIP_LSB 16
`define STAT_STATE_LSB 26
`define STAT_ERR_BIT 29
`define STAT_SET_BIT 30
// Base current ratio, hundredths of relay rated current
`define BASE_MIN 8'h1e
`define BASE_MAX 8'h78
`define R0_HI 8'h2a
`define R1_LO 8'h2b
`define R1_HI 8'h3c
`define R2_LO 8'h3d
`define R2_HI 8'h54
`define R3_LO 8'h55
`define R0_DEF 8'h23
`define R1_DEF 8'h32
`define R2_DEF 8'h46
`define R3_DEF 8'h64
// Currents in hundredths of base current
`define LOW_CURRENT 16'h000a
// Mode numbering
`define MODE_SPACING 10'h032
`define MODE_INSTR_LO 10'h384
`define MODE_INSTR_HI 10'h3e7
// Reset values
`define DEF_SETTING 32'h00000000
`define DEF_MATRIX 9'h000
`define DEF_RATIO 8'h5f
`define DEF_RUNUP 16'h00c8
`define DEF_HEAT_LIM 32'hffffffff
`endif

// ===== tb/ct_model.sv
`timescale 1ns/1ps
// Motor current transformers: step at once, or ramp like a real run-up
module ct_model (
  input wire core_clk,
  input wire [15:0] level_req,
  input wire slow,
  output reg [15:0] phase_current
);
  initial phase_current = 16'h0000;
  // Move eight hundredths a cycle when slow
  always @(posedge core_clk) begin
    if (!slow) phase_current <= level_req;
    else if (phase_current + 16'h0008 <= level_req) phase_current <= phase_current + 16'h0008;
    else if (phase_current >= level_req + 16'h0008) phase_current <= phase_current - 16'h0008;
    else phase_current <= level_req;
  end
endmodule

// ===== tb/testbench.sv
`timescale 1ns/1ps
`include "trip_defines.vh"
module testbench;
  reg core_clk, rst_n = 0, awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0, slow = 0, button = 0;
  reg [7:0] awa = 8'h00, ara = 8'h00;
  reg [31:0] wd = 32'h0, d, seed = 32'd52;
  reg [15:0] level = 16'h0000;
  reg th2 = 0;
  reg [1:0] link = 2'h1, rsp;
  reg [9:0] m;
  wire awr, wr_rdy, bv, arr, rv, so1, so2, to1, to2, rerr, run, done;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [15:0] cur;
  integer errors = 0, n_tests = 0, k, i;
  motor_trip_top #(.TICK_CYCLES(10)) u_motor_trip_top (.core_clk(core_clk), .rst_n(rst_n),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rrdy), .phase_current(cur), .range_selector_link(link),
    .reset_button(button), .thermal_above_one(1'b0), .thermal_above_two(th2),
    .thermal_above_three(1'b0), .start_limit_exceeded(1'b0), .signal_output_one(so1),
    .signal_output_two(so2), .trip_output_one(to1), .trip_output_two(to2),
    .range_error(rerr), .runup_active(run), .start_complete(done));
  ct_model u_ct_model (.core_clk(core_clk), .level_req(level), .slow(slow), .phase_current(cur));
  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  // Random source
  function [31:0] xs(input [31:0] x);
    reg [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xs = y ^ (y << 5);
    end
  endfunction
  // Mode readback: mod fifty, group, mode
  function [18:0] mode_exp(input [9:0] v);
    reg [5:0] r;
    reg [2:0] g;
    begin
      r = v % 50;
      g = v < 200 ? v / 50 : (v >= 900 && v <= 999) ? 3'h4 : 3'h7;
      mode_exp = {r, g, v};
    end
  endfunction
  task summarize;
    begin
      $display("tests %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("BAD %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task chkb(input b, input e);
    chk({31'h0, b}, {31'h0, e});
  endtask
  task tmo;
    begin
      errors = errors + 1;
      $display("BAD %0t wait ran out", $time);
      summarize;
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge core_clk);
  endtask
  // Write: address and data together, ready given once response shows
  task wr(input [7:0] a, input [31:0] v);
    begin
      awa <= a; wd <= v; awv <= 1; wv <= 1;
      for (k = 0; k < 99; k = k + 1) begin
        @(posedge core_clk);
        if (awr) awv <= 0;
        if (wr_rdy) wv <= 0;
        if (bv && brdy) break;
        if (bv) brdy <= 1;
      end
      if (k == 99) tmo;
      brdy <= 0; rsp = bresp;
    end
  endtask
  task rd(input [7:0] a);
    begin
      ara <= a; arv <= 1;
      for (k = 0; k < 99; k = k + 1) begin
        @(posedge core_clk);
        if (arr) arv <= 0;
        if (rv && rrdy) break;
        if (rv) rrdy <= 1;
      end
      if (k == 99) tmo;
      rrdy <= 0; d = rdata; rsp = rresp;
    end
  endtask
  task press;
    begin
      button <= 1; cyc(3); button <= 0; cyc(3);
    end
  endtask
  // Relay pins after the output lag: {trip two, trip one, signal two, signal one}
  task relays(input [3:0] e);
    begin
      cyc(4);
      chk({28'h0, to2, to1, so2, so1}, {28'h0, e});
    end
  endtask
  task wait_run(input e);
    begin
      for (i = 0; i < 1100 && run !== e; i = i + 1) @(posedge core_clk);
      if (i == 1100) tmo;
    end
  endtask
  initial begin
    cyc(2); rst_n <= 1; cyc(3);
    for (i = 0; i < 12; i = i + 1) begin
      seed = xs(seed);
      m = i == 0 ? 10'd49 : i == 1 ? 10'd999 : i == 2 ? 10'd899 : seed[9:0];
      wr(`OFF_MODE, {22'h0, m}); rd(`OFF_MODE);
      chk({13'h0, d[21:16], d[14:12], d[9:0]}, {13'h0, mode_exp(m)});
    end
    rd(8'h38); chk({30'h0, rsp}, 32'h2); chk(d, 32'h0);
    $display("test modes done");
    wr(`OFF_BASE, 32'h32); wr(`OFF_BASE, 32'h78); rd(`OFF_BASE); chk(d, 32'h32);
    wr(8'h1c, 32'h00050064); link <= 2'h2; cyc(4); chkb(rerr, 1);
    press; chkb(rerr, 0); rd(`OFF_BASE); chk(d, {24'h0, `R2_DEF});
    rd(8'h1c); chk(d, `DEF_SETTING);
    $display("test range done");
    wr(`OFF_MAT0, 32'h41); wr(`OFF_SET0, 32'h64);
    for (i = 0; i < 6; i = i + 1) begin
      seed = xs(seed);
      if (i == 3) wr(`OFF_MAT0, 32'h141);
      level <= 16'd101 + {7'h0, seed[8:0]}; relays(4'h5);
      level <= 16'h0032; relays(i >= 3 ? 4'h4 : 4'h0);
      if (i >= 3) begin
        press; relays(4'h0);
      end
    end
    wr(8'h5c, 32'h80); th2 <= 1; relays(4'h8);
    th2 <= 0; relays(4'h0);
    $display("test trips done");
    level <= 16'h0000; cyc(5); wr(`OFF_CMD, 32'h4); slow <= 1; level <= 16'd300;
    wait_run(1'b1); chkb(run, 1); cyc(400);
    rd(`OFF_HEAT_ACC); chkb(d != 0, 1); level <= 16'd50; wait_run(1'b0);
    for (i = 0; i < 5200 && done !== 1'b1; i = i + 1) @(posedge core_clk);
    chkb(i >= 4950 && i < 5100, 1);
    level <= 16'h0000; cyc(60); rd(`OFF_STATUS); chk({29'h0, d[28:26]}, 32'h0);
    level <= 16'd150; cyc(1100); level <= 16'd300; cyc(100); chkb(run, 0);
    $display("test run-up done");
    summarize;
  end
endmodule

// ===== tb/trip_monitor.sv
`timescale 1ns/1ps
`include "trip_defines.vh"
module trip_monitor (
  input wire core_clk,
  input wire rst_n,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire [15:0] phase_current,
  input wire reset_button,
  input wire signal_output_one,
  input wire signal_output_two,
  input wire trip_output_one,
  input wire trip_output_two,
  input wire range_error,
  input wire runup_active,
  input wire start_complete
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Any relay driven
  wire relays = signal_output_one | signal_output_two | trip_output_one | trip_output_two;
  // Cycles since the button was last high, saturating
  reg [2:0] calm_r;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) calm_r <= 3'h0;
    else if (reset_button) calm_r <= 3'h0;
    else if (calm_r != 3'h7) calm_r <= calm_r + 3'h1;
  end
  a_error_blocks_relays: assert property (range_error [*3] |-> !relays)
    else $error("relay driven during range error");
  a_error_holds: assert property (range_error && calm_r == 3'h7 |=> range_error)
    else $error("range error cleared without press");
  a_complete_pulse: assert property (start_complete |=> !start_complete)
    else $error("start complete longer than one cycle");
  a_complete_not_runup: assert property (start_complete |-> !runup_active)
    else $error("start complete during run-up");
  a_settle_wait: assert property ($fell(runup_active) |-> !start_complete [*8])
    else $error("start complete too soon after run-up");
  a_runup_drops: assert property ((phase_current < `LOW_CURRENT) [*4] |-> !runup_active)
    else $error("run-up held with no current");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
endmodule
bind motor_trip_top trip_monitor u_trip_monitor (.core_clk, .rst_n, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .phase_current, .reset_button,
  .signal_output_one, .signal_output_two, .trip_output_one, .trip_output_two, .range_error,
  .runup_active, .start_complete);

// ===== verilog/motor_trip_top.v
`timescale 1ns/1ps
`include "trip_defines.vh"
module motor_trip_top #(
  parameter TICK_CYCLES = `TICK_CYCLES,
  parameter NFN = 9
) (
  input wire core_clk,
  input wire rst_n,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [15:0] phase_current,
  input wire [1:0] range_selector_link,
  input wire reset_button,
  input wire thermal_above_one,
  input wire thermal_above_two,
  input wire thermal_above_three,
  input wire start_limit_exceeded,
  output reg signal_output_one,
  output reg signal_output_two,
  output reg trip_output_one,
  output reg trip_output_two,
  output reg range_error,
  output reg runup_active,
  output reg start_complete
);
  // Run-up machine states
  localparam ST_ARMED = 3'h0;
  localparam ST_TIMING = 3'h1;
  localparam ST_RUNUP = 3'h2;
  localparam ST_SETTLE = 3'h3;
  localparam ST_NORMAL = 3'h4;
  ////////////////////////////////////////////////////////////////////
  // Helper functions
  // Lower bound of a link range
  function [7:0] range_lo(input [1:0] sel);
    case (sel)
      2'h0: range_lo = `BASE_MIN;
      2'h1: range_lo = `R1_LO;
      2'h2: range_lo = `R2_LO;
      default: range_lo = `R3_LO;
    endcase
  endfunction
  // Upper bound of a link range
  function [7:0] range_hi(input [1:0] sel);
    case (sel)
      2'h0: range_hi = `R0_HI;
      2'h1: range_hi = `R1_HI;
      2'h2: range_hi = `R2_HI;
      default: range_hi = `BASE_MAX;
    endcase
  endfunction
  // Default base ratio of a link range
  function [7:0] range_def(input [1:0] sel);
    case (sel)
      2'h0: range_def = `R0_DEF;
      2'h1: range_def = `R1_DEF;
      2'h2: range_def = `R2_DEF;
      default: range_def = `R3_DEF;
    endcase
  endfunction
  // Byte-lane merge of a bus write
  function [31:0] wmerge(input [31:0] old, input [31:0] nw, input [3:0] strb);
    integer b;
    begin
      wmerge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) wmerge[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
  endfunction
  // Byte-lane merge of a matrix word, nine bits kept
  function [8:0] mat_merge(input [8:0] old, input [31:0] nw, input [3:0] strb);
    reg [31:0] full;
    begin
      full = wmerge({23'h0, old}, nw, strb);
      mat_merge = full[8:0];
    end
  endfunction
  // Mode group: 0..3 settings/display/logic/records, 4 instructions
  function [2:0] mode_group(input [9:0] m);
    if (m < `MODE_SPACING) mode_group = 3'h0;
    else if (m < 2 * `MODE_SPACING) mode_group = 3'h1;
    else if (m < 3 * `MODE_SPACING) mode_group = 3'h2;
    else if (m < 4 * `MODE_SPACING) mode_group = 3'h3;
    else if (m >= `MODE_INSTR_LO && m <= `MODE_INSTR_HI) mode_group = 3'h4;
    else mode_group = 3'h7;
  endfunction
  ////////////////////////////////////////////////////////////////////
  // Reset release through two flops
  reg rst_m_r;
  reg rst_sync_n;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_m_r <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_sync_n <= rst_m_r;
    end
  end
  // Shared timing tick
  wire tick;
  tick_divider #(.CYCLES(TICK_CYCLES)) u_tick (
    .core_clk(core_clk),
    .rst_sync_n(rst_sync_n),
    .tick_r(tick)
  );
  ////////////////////////////////////////////////////////////////////
  // Bus write channel
  reg aw_got_r;
  reg w_got_r;
  reg [7:0] waddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  wire wr_do = aw_got_r & w_got_r & ~s_axi_bvalid;
  wire wr_mapped = (waddr_r <= `OFF_HEAT_ACC) ||
                   (waddr_r >= `OFF_MAT0 && waddr_r < `OFF_MAT0 + 4 * NFN);
  // Address and data taken in either order, answered together
  always @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      waddr_r <= 8'h00;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        waddr_r <= {s_axi_awaddr[7:2], 2'h0};
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_do) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Settings storage
  reg [7:0] base_r;
  reg base_set_r;
  reg [1:0] range_r;
  reg err_r;
  reg [31:0] setw [0:5];
  reg [8:0] mat [0:NFN-1];
  reg [15:0] runup_set_r;
  reg [31:0] heat_lim_r;
  reg [7:0] ratio_r;
  reg [9:0] mode_r;
  reg btn_d_r;
  // Command pulses
  wire cmd_wr = wr_do && waddr_r == `OFF_CMD;
  wire reset_press = (reset_button & ~btn_d_r) |
                     (cmd_wr & wdata_r[`CMD_RESET_BIT]);
  wire fsm_cmd_rst = cmd_wr & wdata_r[`CMD_FSM_RST_BIT];
  wire [31:0] base_new = wmerge({24'h0, base_r}, wdata_r, wstrb_r);
  // Merged words, cut to register width where stored
  wire [31:0] mode_new = wmerge({22'h0, mode_r}, wdata_r, wstrb_r);
  wire [31:0] runup_new = wmerge({16'h0, runup_set_r}, wdata_r, wstrb_r);
  wire [31:0] ratio_new = wmerge({24'h0, ratio_r}, wdata_r, wstrb_r);
  // Loop indices, one per process so no two processes share a variable
  integer i;
  integer fn_i;
  integer tm_i;
  integer rl_i;
  integer rd_i;
  // Register writes, range supervision and default loading
  always @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      base_r <= `R0_DEF;
      base_set_r <= 1'b0;
      range_r <= 2'h0;
      err_r <= 1'b0;
      runup_set_r <= `DEF_RUNUP;
      heat_lim_r <= `DEF_HEAT_LIM;
      ratio_r <= `DEF_RATIO;
      mode_r <= 10'h000;
      btn_d_r <= 1'b0;
      for (i = 0; i < 6; i = i + 1) setw[i] <= `DEF_SETTING;
      for (i = 0; i < NFN; i = i + 1) mat[i] <= `DEF_MATRIX;
    end else begin
      btn_d_r <= reset_button;
      if (base_set_r && range_selector_link != range_r) err_r <= 1'b1;
      if (err_r && reset_press) begin
        base_r <= range_def(range_selector_link);
        range_r <= range_selector_link;
        err_r <= 1'b0;
        runup_set_r <= `DEF_RUNUP;
        heat_lim_r <= `DEF_HEAT_LIM;
        ratio_r <= `DEF_RATIO;
        for (i = 0; i < 6; i = i + 1) setw[i] <= `DEF_SETTING;
        for (i = 0; i < NFN; i = i + 1) mat[i] <= `DEF_MATRIX;
      end else if (wr_do) begin
        case (waddr_r)
          `OFF_BASE: begin
            // accept only ratios inside selected range
            if (base_new[7:0] >= range_lo(range_selector_link) &&
                base_new[7:0] <= range_hi(range_selector_link) &&
                base_new[31:8] == 24'h0) begin
              base_r <= base_new[7:0];
              base_set_r <= 1'b1;
              range_r <= range_selector_link;
            end
          end
          `OFF_CMD: begin
            if (wdata_r[`CMD_SELECT_BIT]) begin
              for (i = 0; i < 6; i = i + 1) begin
                if (!wdata_r[`CMD_MASK_LSB + i]) setw[i] <= `DEF_SETTING;
              end
            end
          end
          `OFF_MODE: mode_r <= mode_new[9:0];
          `OFF_RUNUP: runup_set_r <= runup_new[15:0];
          `OFF_HEAT_LIM: heat_lim_r <= wmerge(heat_lim_r, wdata_r, wstrb_r);
          `OFF_RATIO: ratio_r <= ratio_new[7:0];
          default: begin
            for (i = 0; i < 6; i = i + 1) begin
              if (waddr_r == `OFF_SET0 + 4 * i) setw[i] <= wmerge(setw[i], wdata_r, wstrb_r);
            end
            for (i = 0; i < NFN; i = i + 1) begin
              if (waddr_r == `OFF_MAT0 + 4 * i)
                mat[i] <= mat_merge(mat[i], wdata_r, wstrb_r);
            end
          end
        endcase
      end
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Run-up supervision machine
  reg [2:0] st_r;
  reg [9:0] st_cnt_r;
  reg [3:0] int_cnt_r;
  reg [31:0] heat_acc_r;
  reg heat_trip_r;
  wire low_cur = phase_current < `LOW_CURRENT;
  wire above_runup = phase_current >= runup_set_r;
  wire oc_inhibit = (st_r == ST_ARMED) || (st_r == ST_TIMING) || (st_r == ST_RUNUP);
  wire [31:0] cur_sq = phase_current * phase_current;
  always @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_r <= ST_ARMED;
      st_cnt_r <= 10'h000;
      int_cnt_r <= 4'h0;
      heat_acc_r <= 32'h00000000;
      heat_trip_r <= 1'b0;
      start_complete <= 1'b0;
    end else begin
      start_complete <= 1'b0;
      heat_trip_r <= heat_acc_r > heat_lim_r;
      if (fsm_cmd_rst) begin
        st_r <= ST_ARMED;
        st_cnt_r <= 10'h000;
        heat_acc_r <= 32'h00000000;
      end else begin
        case (st_r)
          ST_ARMED: begin
            st_cnt_r <= 10'h000;
            heat_acc_r <= 32'h00000000;
            if (!low_cur) st_r <= ST_TIMING;
          end
          ST_TIMING: begin
            if (tick) st_cnt_r <= st_cnt_r + 10'h001;
            if (low_cur) st_r <= ST_ARMED;
            else if (above_runup) begin
              st_r <= ST_RUNUP;
              int_cnt_r <= 4'h0;
            end else if (st_cnt_r >= `RUNUP_WINDOW_TICKS) begin
              st_r <= ST_NORMAL;
            end
          end
          ST_RUNUP: begin
            if (tick) begin
              if (int_cnt_r == `INTEG_TICKS - 1) begin
                int_cnt_r <= 4'h0;
                heat_acc_r <= heat_acc_r + cur_sq;
              end else begin
                int_cnt_r <= int_cnt_r + 4'h1;
              end
            end
            if (!above_runup) begin
              st_r <= ST_SETTLE;
              st_cnt_r <= 10'h000;
            end
          end
          ST_SETTLE: begin
            if (tick) st_cnt_r <= st_cnt_r + 10'h001;
            if (above_runup) st_r <= ST_RUNUP;
            else if (st_cnt_r >= `SETTLE_TICKS) begin
              st_r <= ST_NORMAL;
              start_complete <= 1'b1;
            end
          end
          ST_NORMAL: begin
            if (low_cur) st_r <= ST_ARMED;
          end
          default: st_r <= ST_ARMED;
        endcase
      end
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Per-function pick-up, timing and trip
  reg [15:0] tmr [0:5];
  reg [5:0] fn_trip_r;
  reg [NFN-1:0] latch_r;
  reg [5:0] active;
  reg [5:0] exceed;
  reg [5:0] dropped;
  reg [NFN-1:0] start_vec;
  reg [NFN-1:0] trip_raw;
  reg [NFN-1:0] trip_vec;
  reg [31:0] cur_x100;
  reg [31:0] pick_x;
  // Combinational pick-up decisions
  always @* begin
    cur_x100 = phase_current * 32'd100;
    for (fn_i = 0; fn_i < 6; fn_i = fn_i + 1) begin
      // zero pick-up and delay is inactive
      active[fn_i] = setw[fn_i] != 32'h0;
      pick_x = setw[fn_i][15:0] * ratio_r;
      // each stage on its own settings
      exceed[fn_i] = active[fn_i] && phase_current >= setw[fn_i][15:0];
      dropped[fn_i] = cur_x100 < pick_x;
    end
    // no-load between 0.1 base and setting
    exceed[5] = active[5] && !low_cur && phase_current < setw[5][15:0];
    dropped[5] = !exceed[5];
    // overcurrent stages 2 to 4 and no-load blocked in armed, timing and run-up states
    for (fn_i = 2; fn_i < 6; fn_i = fn_i + 1) begin
      if (oc_inhibit) exceed[fn_i] = 1'b0;
    end
    start_vec = {1'b0, thermal_above_one & thermal_above_three,
                 st_r == ST_RUNUP, exceed};
    // delay, heat limit, second threshold or start count
    trip_raw = {start_limit_exceeded, thermal_above_two, heat_trip_r, fn_trip_r};
    trip_vec = trip_raw | latch_r;
  end
  // Delay timers and trip state
  always @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      fn_trip_r <= 6'h00;
      latch_r <= {NFN{1'b0}};
      for (tm_i = 0; tm_i < 6; tm_i = tm_i + 1) tmr[tm_i] <= 16'h0000;
    end else begin
      for (tm_i = 0; tm_i < 6; tm_i = tm_i + 1) begin
        if (exceed[tm_i]) begin
          if (tick && tmr[tm_i] < setw[tm_i][31:16]) tmr[tm_i] <= tmr[tm_i] + 16'h0001;
          if (tmr[tm_i] >= setw[tm_i][31:16]) fn_trip_r[tm_i] <= 1'b1;
        end else begin
          tmr[tm_i] <= 16'h0000;
          if (dropped[tm_i] || !active[tm_i]) fn_trip_r[tm_i] <= 1'b0;
        end
      end
      // latched trip held until reset press
      for (tm_i = 0; tm_i < NFN; tm_i = tm_i + 1) begin
        if (trip_raw[tm_i] && mat[tm_i][`MAT_LATCH_BIT]) latch_r[tm_i] <= 1'b1;
        else if (reset_press) latch_r[tm_i] <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Output matrix and status outputs
  reg [3:0] relay_nxt;
  always @* begin
    relay_nxt = 4'h0;
    for (rl_i = 0; rl_i < NFN; rl_i = rl_i + 1) begin
      relay_nxt = relay_nxt | ({4{start_vec[rl_i]}} & mat[rl_i][3:0]) |
                  ({4{trip_vec[rl_i]}} & mat[rl_i][7:4]);
    end
    if (err_r) relay_nxt = 4'h0;
  end
  always @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      signal_output_one <= 1'b0;
      signal_output_two <= 1'b0;
      trip_output_one <= 1'b0;
      trip_output_two <= 1'b0;
      range_error <= 1'b0;
      runup_active <= 1'b0;
    end else begin
      signal_output_one <= relay_nxt[0];
      signal_output_two <= relay_nxt[1];
      trip_output_one <= relay_nxt[2];
      trip_output_two <= relay_nxt[3];
      range_error <= err_r;
      runup_active <= st_r == ST_RUNUP;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Bus read channel
  reg [31:0] rd_word;
  reg rd_ok;
  wire [7:0] ra = {s_axi_araddr[7:2], 2'h0};
  // Chosen mode modulo the group spacing
  wire [9:0] mode_mod = mode_r % `MODE_SPACING;
  always @* begin
    rd_ok = 1'b1;
    rd_word = 32'h00000000;
    case (ra)
      `OFF_BASE: rd_word = {24'h0, base_r};
      `OFF_STATUS: rd_word = {1'b0, base_set_r, err_r, st_r, 1'b0,
                              trip_vec, 7'h0, start_vec};
      `OFF_CMD: rd_word = 32'h00000000;
      `OFF_MODE: rd_word = {10'h0, mode_mod[5:0], 1'b0,
                            mode_group(mode_r), 2'h0, mode_r};
      `OFF_RUNUP: rd_word = {16'h0, runup_set_r};
      `OFF_HEAT_LIM: rd_word = heat_lim_r;
      `OFF_RATIO: rd_word = {24'h0, ratio_r};
      `OFF_HEAT_ACC: rd_word = heat_acc_r;
      default: begin
        rd_ok = 1'b0;
        for (rd_i = 0; rd_i < 6; rd_i = rd_i + 1) begin
          if (ra == `OFF_SET0 + 4 * rd_i) begin
            rd_word = setw[rd_i];
            rd_ok = 1'b1;
          end
        end
        for (rd_i = 0; rd_i < NFN; rd_i = rd_i + 1) begin
          if (ra == `OFF_MAT0 + 4 * rd_i) begin
            rd_word = {23'h0, mat[rd_i]};
            rd_ok = 1'b1;
          end
        end
      end
    endcase
  end
  always @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule

// ===== verilog/tick_divider.v
`timescale 1ns/1ps
// Periodic one-cycle tick for all protection timing
module tick_divider #(
  parameter CYCLES = 100000
) (
  input wire core_clk,
  input wire rst_sync_n,
  output reg tick_r
);
  // Cycle counter
  reg [31:0] cnt_r;
  ////////////////////////////////////////////////////////////////////
  // Count up a full period, pulse once
  always @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cnt_r <= 32'h00000000;
      tick_r <= 1'b0;
    end else if (cnt_r == CYCLES - 1) begin
      cnt_r <= 32'h00000000;
      tick_r <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 32'h00000001;
      tick_r <= 1'b0;
    end
  end
endmodule
